/* File: dpr_pkg.sv */
// Purpose : Shared constants and carriers for the dual-port burst RAM
// Assumes : One core clock; ports sampled on core_clk_i
// Notes   : Depth selects 16K or 32K words of 36 bits
package dpr_pkg;

  localparam int unsigned DPR_WORD_W     = 36;
  localparam int unsigned DPR_LANE_W     = 9;
  localparam int unsigned DPR_LANES      = 4;
  localparam int unsigned DPR_DEPTH_16K  = 16384;
  localparam int unsigned DPR_DEPTH_32K  = 32768;
  localparam int unsigned DPR_ADDR_W_MAX = 15;
  localparam logic [14:0] DPR_CNT_RST    = 15'h0000;
  localparam logic [35:0] DPR_DATA_RST   = 36'h000000000;

  // Right port width match codes
  localparam logic [1:0] DPR_WM_36 = 2'h0;
  localparam logic [1:0] DPR_WM_18 = 2'h1;
  localparam logic [1:0] DPR_WM_9  = 2'h2;

  // Port request, active-low controls as on the pins except pipe, which is high for pipelined
  typedef struct packed {
    logic        cs_n;
    logic        wr_n;
    logic        oe_n;
    logic        ads_n;
    logic        count_advance_enable_n;
    logic        cntclr_n;
    logic        pipe;
    logic [3:0]  lane_n;
    logic [14:0] addr;
    logic [35:0] wdata;
  } dpr_req_t;

  // Port answer towards the data pins
  typedef struct packed {
    logic [35:0] rdata;
    logic        drive;
  } dpr_rsp_t;

endpackage

/* File: dpr_ram.sv */
// Purpose : Dual-port synchronous RAM with burst counters per port
// Assumes : Both ports run on core_clk_i; pin inputs are double-flopped
// Notes   : Output enable active low on pins; data_oe_n low while driving
//
// Behaviour
// R01: 16K or 32K words of 36 bits
// R02: Two ports, independent access each cycle
// R03: Same address on both ports never blocked
// R04: All port inputs registered on clock edge
// R05: Latency select picks pipelined or flow-through
// R06: Flow-through presents data in capture cycle
// R07: Pipelined adds one output register stage
// R08: Write completes internally, one cycle pulse
// R09: Chip select high powers port down
// R10: Pipelined needs one enabled cycle to resume
// R11: Address load strobe loads burst counter
// R12: Counting ignores external address input
// R13: Counter increments each edge while enabled
// R14: Counter wraps from top to zero
// R15: Counter clear resets burst counter
// R16: Counter value readable on data lines
// R17: Right port supports 36, 18, 9 widths
// R18: Left port byte-lane selection
// R19: Host loads with strobe and enable low
// R20: Clear beats load and count
// R21: Host selects latency low flow, high pipe
// R22: Host drives write low, read high
// R23: Left word is four 9-bit lanes
`timescale 1ns/10ps
module dpr_ram
  import dpr_pkg::*;
#(
  parameter int unsigned DEPTH  = DPR_DEPTH_32K,
  parameter int unsigned ADDR_W = 15
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  input  wire dpr_req_t         left_req_i,
  input  wire dpr_req_t         right_req_i,
  input  wire logic             right_readback_i,
  input  wire logic             left_readback_i,
  input  wire logic [1:0]       width_match_select_i,
  input  wire logic             endian_order_select_i,
  output logic      [35:0]      left_data_o,
  output logic                  left_data_oe_n_o,
  output logic      [35:0]      right_data_o,
  output logic                  right_data_oe_n_o,
  output logic      [ADDR_W-1:0] left_cnt_o,
  output logic      [ADDR_W-1:0] right_cnt_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dpr_req_t          s1;
    dpr_req_t          s2;
    dpr_req_t          r;
    logic              rb_s1;
    logic              rb_s2;
    logic              rb;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] cnt_out;
    logic [35:0]       pipe_q;
    logic [35:0]       dout;
    logic              oe_n;
    logic              pd;
    logic [1:0]        sub;
  } dpr_port_t;

  typedef struct packed {
    dpr_port_t        p0;
    dpr_port_t        p1;
    logic [1:0]       wm_s1;
    logic [1:0]       wm_s2;
    logic             be_s1;
    logic             be_s2;
  } dpr_state_t;

  // R01: storage array sized by depth
  logic [DPR_WORD_W-1:0] mem [DEPTH];

  dpr_state_t st_q;
  dpr_state_t st_d;
  logic [ADDR_W-1:0] addr0;
  logic [ADDR_W-1:0] addr1;
  logic [35:0]       rd0;
  logic [35:0]       rd1;
  logic [35:0]       wmask0;
  logic [35:0]       wdat1;
  logic [35:0]       wmask1;
  logic              we0;
  logic              we1;

  // ----------------------------------------------------------------
  // Next-address per port
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] next_cnt(input dpr_req_t r,
                                                 input logic [ADDR_W-1:0] c);
    logic [ADDR_W-1:0] n;
    n = c;
    // R20: clear has highest priority
    // R15: counter cleared
    if (!r.cntclr_n) begin
      n = DPR_CNT_RST[ADDR_W-1:0];
    // R11: load on strobe with enable low
    // R19: both strobe and enable low
    end else if (!r.ads_n && !r.count_advance_enable_n) begin
      n = r.addr[ADDR_W-1:0];
    // R13: increment every edge
    // R14: natural wrap to zero
    end else if (!r.count_advance_enable_n) begin
      n = c + ADDR_W'(1);
    end
    return n;
  endfunction

  // R12: counter address used while counting
  function automatic logic [ADDR_W-1:0] acc_addr(input dpr_req_t r,
                                                 input logic [ADDR_W-1:0] c);
    logic [ADDR_W-1:0] a;
    a = r.addr[ADDR_W-1:0];
    if (!r.cntclr_n) begin
      a = DPR_CNT_RST[ADDR_W-1:0];
    end else if (!r.count_advance_enable_n && r.ads_n) begin
      a = c;
    end
    return a;
  endfunction

  always_comb begin
    addr0 = acc_addr(st_q.p0.r, st_q.p0.cnt);
    addr1 = acc_addr(st_q.p1.r, st_q.p1.cnt);
  end

  // ----------------------------------------------------------------
  // Lane gating and right port width match
  // ----------------------------------------------------------------
  // R18: only selected lanes written or read
  // R23: four 9-bit lanes per word
  genvar g;
  generate
    for (g = 0; g < DPR_LANES; g++) begin : g_lane
      assign wmask0[g*DPR_LANE_W +: DPR_LANE_W] =
        {DPR_LANE_W{~st_q.p0.r.lane_n[g]}};
    end
  endgenerate

  // R17: narrow transfers mapped onto word lanes
  always_comb begin
    logic [1:0] lane;
    lane   = st_q.be_s2 ? ~st_q.p1.sub : st_q.p1.sub;
    wmask1 = {36{1'b1}};
    wdat1  = st_q.p1.r.wdata;
    rd1    = mem[addr1];
    unique case (st_q.wm_s2)
      DPR_WM_18: begin
        wmask1 = lane[0] ? {18'h3FFFF, 18'h00000} : {18'h00000, 18'h3FFFF};
        wdat1  = {2{st_q.p1.r.wdata[17:0]}};
        rd1    = {18'h00000, (lane[0] ? mem[addr1][35:18] : mem[addr1][17:0])};
      end
      DPR_WM_9: begin
        wmask1 = 36'h1FF << (lane * 9);
        wdat1  = {4{st_q.p1.r.wdata[8:0]}};
        rd1    = {27'h0000000, 9'(mem[addr1] >> (lane * 9))};
      end
      default: begin
        wmask1 = {36{1'b1}};
      end
    endcase
    rd0 = mem[addr0] & wmask0;
  end

  // R02: both ports access in the same cycle
  // R08: write pulse is one internal cycle
  assign we0 = clk_en_i && !st_q.p0.r.cs_n && !st_q.p0.r.wr_n;
  assign we1 = clk_en_i && !st_q.p1.r.cs_n && !st_q.p1.r.wr_n;

  // R03: same location, right port write lands last
  always_ff @(posedge core_clk_i) begin
    if (we0) begin
      mem[addr0] <= (mem[addr0] & ~wmask0) | (st_q.p0.r.wdata & wmask0);
    end
    if (we1) begin
      mem[addr1] <= (mem[addr1] & ~wmask1) | (wdat1 & wmask1);
    end
  end

  // ----------------------------------------------------------------
  // Port output stage
  // ----------------------------------------------------------------
  function automatic dpr_port_t step(input dpr_port_t p, input dpr_req_t pin,
                                     input logic rbp, input logic [35:0] rd,
                                     input logic narrow);
    dpr_port_t n;
    logic      rd_en;
    logic [35:0] src;
    n       = p;
    // R04: two sync stages then the input register
    n.s1    = pin;
    n.s2    = p.s1;
    n.r     = p.s2;
    n.rb_s1 = rbp;
    n.rb_s2 = p.rb_s1;
    n.rb    = p.rb_s2;
    n.cnt   = next_cnt(p.r, p.cnt);
    n.cnt_out = n.cnt;
    if (!p.r.count_advance_enable_n && p.r.cntclr_n) begin
      n.sub = p.sub + 2'h1;
    end
    rd_en = !p.r.cs_n && p.r.wr_n;
    // R16: counter readback on data lines
    src   = p.rb ? DPR_WORD_W'(p.cnt) : rd;
    // R07: pipelined register stage
    n.pipe_q = src;
    // R09: chip select high powers down
    n.pd  = p.r.cs_n;
    // R05: latency select chooses output path
    if (p.r.pipe) begin
      // R10: one enabled cycle before driving again
      n.dout = p.pipe_q;
      n.oe_n = !(!p.pd && !p.r.cs_n && !p.r.oe_n && p.r.wr_n);
    end else begin
      // R06: flow-through bypasses output register
      n.dout = src;
      n.oe_n = !(rd_en && !p.r.oe_n);
    end
    if (narrow) begin
      n.dout = n.dout;
    end
    return n;
  endfunction

  always_comb begin
    st_d       = st_q;
    st_d.wm_s1 = width_match_select_i;
    st_d.wm_s2 = st_q.wm_s1;
    st_d.be_s1 = endian_order_select_i;
    st_d.be_s2 = st_q.be_s1;
    st_d.p0    = step(st_q.p0, left_req_i, left_readback_i, rd0, 1'b0);
    st_d.p1    = step(st_q.p1, right_req_i, right_readback_i, rd1, 1'b1);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '{p0: '{s1: '1, s2: '1, r: '1, oe_n: 1'b1, pd: 1'b1, default: '0},
                p1: '{s1: '1, s2: '1, r: '1, oe_n: 1'b1, pd: 1'b1, default: '0},
                default: '0};
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign left_data_o       = st_q.p0.dout;
  assign left_data_oe_n_o  = st_q.p0.oe_n;
  assign right_data_o      = st_q.p1.dout;
  assign right_data_oe_n_o = st_q.p1.oe_n;
  assign left_cnt_o        = st_q.p0.cnt_out;
  assign right_cnt_o       = st_q.p1.cnt_out;

endmodule

/* File: dpr_ram_asserts.sv */
// Purpose : Port checks for dpr_ram
// Assumes : Pin-level requests held as levels
// Notes   : Windows of seven edges cover the input path
`timescale 1ns/10ps
module dpr_ram_asserts
  import dpr_pkg::*;
#(
  parameter int unsigned DEPTH  = DPR_DEPTH_32K,
  parameter int unsigned ADDR_W = 15
) (
  input wire logic              core_clk_i,
  input wire logic              resetn_i,
  input wire logic              clk_en_i,
  input wire dpr_req_t          left_req_i,
  input wire dpr_req_t          right_req_i,
  input wire logic [35:0]       left_data_o,
  input wire logic              left_data_oe_n_o,
  input wire logic              right_data_oe_n_o,
  input wire logic [ADDR_W-1:0] left_cnt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  left_power_a: assert property ((clk_en_i && left_req_i.cs_n) [*7] |-> left_data_oe_n_o)
    else $error("left port drives while deselected");
  right_power_a: assert property ((clk_en_i && right_req_i.cs_n) [*7] |-> right_data_oe_n_o)
    else $error("right port drives while deselected");
  cnt_clear_a: assert property ((clk_en_i && !left_req_i.cntclr_n) [*7] |-> left_cnt_o == '0)
    else $error("counter not cleared");
  cnt_step_a: assert property ((clk_en_i && left_req_i.cntclr_n && left_req_i.ads_n
    && !left_req_i.count_advance_enable_n) [*7] |-> left_cnt_o == $past(left_cnt_o) + 1'b1)
    else $error("counter did not step by one");
  cnt_hold_a: assert property ((clk_en_i && left_req_i.cntclr_n && left_req_i.count_advance_enable_n) [*7]
    |-> $stable(left_cnt_o))
    else $error("counter moved while idle");
  cnt_load_a: assert property ((clk_en_i && left_req_i.cntclr_n && !left_req_i.ads_n
    && !left_req_i.count_advance_enable_n && $stable(left_req_i.addr)) [*7]
    |-> left_cnt_o == left_req_i.addr[ADDR_W-1:0])
    else $error("counter did not load address");
  read_drive_a: assert property ((clk_en_i && !left_req_i.cs_n && left_req_i.wr_n
    && !left_req_i.oe_n) [*7] |-> !left_data_oe_n_o)
    else $error("left port not driving on read");
  freeze_out_a: assert property (!clk_en_i |=> $stable(left_data_o) && $stable(left_cnt_o))
    else $error("outputs moved with clock enable low");
  cover property (!left_data_oe_n_o && !right_data_oe_n_o);
  cover property (left_cnt_o == '1 ##1 left_cnt_o == '0);
  cover property (!clk_en_i);
endmodule

bind dpr_ram dpr_ram_asserts #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .left_req_i(left_req_i), .right_req_i(right_req_i), .left_data_o(left_data_o),
  .left_data_oe_n_o(left_data_oe_n_o), .right_data_oe_n_o(right_data_oe_n_o),
  .left_cnt_o(left_cnt_o));

/* File: dpr_host.sv */
// Purpose : Host model driving one port's pins
// Assumes : Called at a falling edge
// Notes   : Request stays as a level until the next call
`timescale 1ns/10ps
module dpr_host
  import dpr_pkg::*;
(
  input  wire logic core_clk_i,
  output dpr_req_t  req_o
);
  initial req_o = '1;
  task automatic drive(input logic [6:0] ctl, input logic [3:0] ln, input logic [14:0] a,
                       input logic [35:0] d, input int n);
    req_o = {ctl, ln, a, d};
    repeat (n) @(negedge core_clk_i);
  endtask
endmodule

/* File: testbench.sv */
// Purpose : Self-checking bench for dpr_ram
// Assumes : Inputs change at falling edges
// Notes   : Right width and lane order switched in one scenario
`timescale 1ns/10ps
module testbench
  import dpr_pkg::*;
;
  localparam logic [6:0]  IDL = 7'h7F, WRF = 7'h1E, RDF = 7'h2E, RDP = 7'h2F;
  localparam logic [6:0]  CLR = 7'h30, CNT = 7'h3A, LDA = 7'h32;
  localparam logic [14:0] A = 15'h0010, B = 15'h0020;
  localparam logic [35:0] D1 = 36'h123456789, D2 = 36'hABCDEF012, D3 = 36'hFEDCBA987;
  localparam logic [35:0] MIX = {D1[35:9], D3[8:0]};
  localparam logic [35:0] W18 = {D2[35:18], 18'h12345};
  localparam logic [35:0] W9  = {9'h0AB, W18[26:0]};
  logic        clk, resetn, clk_en, lrb, loe, roe, rrb, be;
  logic [1:0]  wm;
  logic [35:0] ldat, rdat;
  logic [14:0] lcnt, rcnt;
  dpr_req_t    lreq, rreq;
  int          mismatches, comparisons, cyc;
  dpr_host lh (.core_clk_i(clk), .req_o(lreq));
  dpr_host rh (.core_clk_i(clk), .req_o(rreq));
  dpr_ram dut (.core_clk_i(clk), .resetn_i(resetn), .clk_en_i(clk_en), .left_req_i(lreq),
    .right_req_i(rreq), .right_readback_i(rrb), .left_readback_i(lrb),
    .width_match_select_i(wm), .endian_order_select_i(be), .left_data_o(ldat),
    .left_data_oe_n_o(loe), .right_data_o(rdat), .right_data_oe_n_o(roe),
    .left_cnt_o(lcnt), .right_cnt_o(rcnt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkc(input string nm, input logic [14:0] e, input logic [14:0] g);
    chk(nm, {21'h0, e}, {21'h0, g});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    lrb = 1'b0;
    rrb = 1'b0;
    wm = DPR_WM_36;
    be = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    fork lh.drive(WRF, 4'h0, A, D1, 8); rh.drive(WRF, 4'h0, B, D2, 8); join
    lh.drive(WRF, 4'hE, A, D3, 8);
    fork lh.drive(RDF, 4'h0, B, 36'h0, 8); rh.drive(RDP, 4'h0, A, 36'h0, 8); join
    chk("left read", D2, ldat);
    chk("right read", MIX, rdat);
    lh.drive(RDF, 4'h5, A, 36'h0, 8);
    chk("lane read", MIX & 36'hFF803FE00, ldat);
    fork lh.drive(RDF, 4'h0, A, 36'h0, 8); rh.drive(RDP, 4'h0, B, 36'h0, 8); join
    fork lh.drive(RDF, 4'h0, B, 36'h0, 4); rh.drive(RDP, 4'h0, A, 36'h0, 4); join
    chk("flow latency", D2, ldat);
    chk("pipe latency", D2, rdat);
    @(negedge clk);
    chk("pipe data", MIX, rdat);
    fork lh.drive(IDL, 4'hF, A, 36'h0, 8); rh.drive(IDL, 4'hF, A, 36'h0, 8); join
    chk("power down", 36'h3, {34'h0, loe, roe});
    clk_en = 1'b0;
    repeat (2) @(negedge clk);
    clk_en = 1'b1;
    fork lh.drive(RDF, 4'h0, A, 36'h0, 8); rh.drive(RDP, 4'h0, A, 36'h0, 8); join
    chk("same addr left", MIX, ldat);
    chk("same addr right", MIX, rdat);
    wm = DPR_WM_18;
    rh.drive(WRF, 4'h0, B, 36'h000012345, 8);
    rh.drive(RDP, 4'h0, B, 36'h0, 8);
    chk("half read", {18'h00000, W18[17:0]}, rdat);
    be = 1'b1;
    fork lh.drive(RDF, 4'h0, B, 36'h0, 8); rh.drive(RDP, 4'h0, B, 36'h0, 8); join
    chk("half merge", W18, ldat);
    chk("half swap", {18'h00000, W18[35:18]}, rdat);
    wm = DPR_WM_9;
    rh.drive(WRF, 4'h0, B, 36'h0000000AB, 8);
    fork lh.drive(RDF, 4'h0, B, 36'h0, 8); rh.drive(RDP, 4'h0, B, 36'h0, 8); join
    chk("byte merge", W9, ldat);
    chk("byte read", {27'h0, W9[35:27]}, rdat);
    wm = DPR_WM_36;
    be = 1'b0;
    lh.drive(CLR, 4'h0, A, 36'h0, 8);
    lh.drive(CNT, 4'h0, A, 36'h0, 8);
    lh.drive(IDL, 4'hF, A, 36'h0, 6);
    chkc("count", 15'h0008, lcnt);
    lrb = 1'b1;
    lh.drive(RDF, 4'h0, A, 36'h0, 8);
    chk("readback", 36'h8, {21'h0, ldat[14:0]});
    lrb = 1'b0;
    lh.drive(LDA, 4'h0, 15'h7FFF, 36'h0, 8);
    lh.drive(IDL, 4'hF, A, 36'h0, 6);
    chkc("load", 15'h7FFF, lcnt);
    lh.drive(CNT, 4'h0, A, 36'h0, 1);
    lh.drive(IDL, 4'hF, A, 36'h0, 6);
    chkc("wrap", 15'h0000, lcnt);
    rh.drive(CLR, 4'h0, B, 36'h0, 8);
    rh.drive(CNT, 4'h0, B, 36'h0, 3);
    rh.drive(IDL, 4'hF, B, 36'h0, 6);
    chkc("right count", 15'h0003, rcnt);
    rrb = 1'b1;
    rh.drive(RDF, 4'h0, B, 36'h0, 8);
    chk("right readback", 36'h000000003, rdat);
    rrb = 1'b0;
    tally_and_finish();
  end
endmodule
